// ### sbcsf_exec.sv
// Execution stage for subtract-with-borrow and special page store
`timescale 1ns/1ps

//
// Function
// - Register form adds register, complemented working value and carry, 8 bits.
// - Destination bit 0 writes working register, 1 writes data register back.
// - Register operand is a 7-bit field reaching data registers 0 to 127.
// - Zero set on zero result; carry set when no borrow, cleared on borrow.
// - Store copies working register into special page register 0 to 21.
// - Store takes one cycle, keeps working register and all flags.
// - Immediate form: immediate plus complement plus carry into working register.
module sbcsf_exec
  import sbcsf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              instr_valid,
  input  wire sbcsf_op_t         instr_op,
  input  wire logic [RADDR_W-1:0] instr_raddr,
  input  wire logic              instr_dest,
  input  wire logic [DATA_W-1:0] instr_imm,
  input  wire logic [SSEL_W-1:0] instr_ssel,
  input  wire logic [DATA_W-1:0] file_rdata,
  output logic      [DATA_W-1:0] working_register_ff,
  output logic                   carry_flag_ff,
  output logic                   zero_flag_ff,
  output logic                   low_nibble_carry_flag_ff,
  output logic                   file_we_ff,
  output logic     [RADDR_W-1:0] file_waddr_ff,
  output logic      [DATA_W-1:0] file_wdata_ff,
  output logic                   spage_we_ff,
  output logic      [SSEL_W-1:0] spage_sel_ff,
  output logic      [DATA_W-1:0] spage_wdata_ff,
  output logic                   done_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Operand select and adder

  logic [DATA_W-1:0] opnd;
  logic [DATA_W-1:0] sum;
  logic              cout;
  logic              nib_cout;
  logic              zero;

  // File data for the register form, immediate otherwise
  assign opnd = (instr_op == SBCSF_OP_SUB_REG) ? file_rdata : instr_imm;

  sbcsf_adder u_adder (
    .opnd     (opnd),
    .wreg     (working_register_ff),
    .cin      (carry_flag_ff),
    .sum      (sum),
    .cout     (cout),
    .nib_cout (nib_cout),
    .zero     (zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [DATA_W-1:0]  nxt_working_register;
  logic               nxt_carry_flag;
  logic               nxt_zero_flag;
  logic               nxt_low_nibble_carry_flag;
  logic               nxt_file_we;
  logic [RADDR_W-1:0] nxt_file_waddr;
  logic [DATA_W-1:0]  nxt_file_wdata;
  logic               nxt_spage_we;
  logic [SSEL_W-1:0]  nxt_spage_sel;
  logic [DATA_W-1:0]  nxt_spage_wdata;
  logic               nxt_done;

  always_comb begin
    nxt_working_register      = working_register_ff;
    nxt_carry_flag            = carry_flag_ff;
    nxt_zero_flag             = zero_flag_ff;
    nxt_low_nibble_carry_flag = low_nibble_carry_flag_ff;
    nxt_file_we               = 1'b0;
    nxt_file_waddr            = file_waddr_ff;
    nxt_file_wdata            = file_wdata_ff;
    nxt_spage_we              = 1'b0;
    nxt_spage_sel             = spage_sel_ff;
    nxt_spage_wdata           = spage_wdata_ff;
    nxt_done                  = 1'b0;
    if (instr_valid) begin
      case (instr_op)
        SBCSF_OP_SUB_REG: begin
          nxt_done                  = 1'b1;
          nxt_carry_flag            = cout;
          nxt_zero_flag             = zero;
          nxt_low_nibble_carry_flag = nib_cout;
          if (instr_dest == DEST_FILE) begin
            nxt_file_we    = 1'b1;
            nxt_file_waddr = instr_raddr;
            nxt_file_wdata = sum;
          end else begin
            nxt_working_register = sum;
          end
        end
        SBCSF_OP_SUB_IMM: begin
          nxt_done                  = 1'b1;
          nxt_working_register      = sum;
          nxt_carry_flag            = cout;
          nxt_zero_flag             = zero;
          nxt_low_nibble_carry_flag = nib_cout;
        end
        SBCSF_OP_STORE_SP: begin
          // Index past the page end is dropped rather than aliased
          nxt_done = 1'b1;
          if (instr_ssel <= SPAGE_LAST) begin
            nxt_spage_we    = 1'b1;
            nxt_spage_sel   = instr_ssel;
            nxt_spage_wdata = working_register_ff;
          end
        end
        default: begin
          nxt_done = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (!nrst) begin
      working_register_ff      <= WREG_RST;
      carry_flag_ff            <= FLAG_RST;
      zero_flag_ff             <= FLAG_RST;
      low_nibble_carry_flag_ff <= FLAG_RST;
      file_we_ff               <= 1'b0;
      file_waddr_ff            <= '0;
      file_wdata_ff            <= '0;
      spage_we_ff              <= 1'b0;
      spage_sel_ff             <= '0;
      spage_wdata_ff           <= '0;
      done_ff                  <= 1'b0;
    end else begin
      working_register_ff      <= nxt_working_register;
      carry_flag_ff            <= nxt_carry_flag;
      zero_flag_ff             <= nxt_zero_flag;
      low_nibble_carry_flag_ff <= nxt_low_nibble_carry_flag;
      file_we_ff               <= nxt_file_we;
      file_waddr_ff            <= nxt_file_waddr;
      file_wdata_ff            <= nxt_file_wdata;
      spage_we_ff              <= nxt_spage_we;
      spage_sel_ff             <= nxt_spage_sel;
      spage_wdata_ff           <= nxt_spage_wdata;
      done_ff                  <= nxt_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_sub_reg;
    instr_valid && instr_op == SBCSF_OP_SUB_REG;
  endsequence

  sequence s_sub_imm;
    instr_valid && instr_op == SBCSF_OP_SUB_IMM;
  endsequence

  sequence s_store;
    instr_valid && instr_op == SBCSF_OP_STORE_SP;
  endsequence

  logic [DATA_W-1:0] result_seen;
  assign result_seen = file_we_ff ? file_wdata_ff : working_register_ff;

  chk_reg_sum_value: assert property (
    s_sub_reg |=> {carry_flag_ff, result_seen} ==
      sbcsf_sub9($past(file_rdata), $past(working_register_ff), $past(carry_flag_ff)))
    else $error("register subtract result wrong");

  chk_dest_wreg_only: assert property (
    s_sub_reg ##0 (instr_dest == DEST_WREG) |=> !file_we_ff && done_ff)
    else $error("destination 0 wrote the file");

  chk_dest_file_back: assert property (
    s_sub_reg ##0 (instr_dest == DEST_FILE) |=>
      file_we_ff && file_waddr_ff == $past(instr_raddr) && $stable(working_register_ff))
    else $error("destination 1 write-back wrong");

  chk_zero_and_carry: assert property (
    (s_sub_reg or s_sub_imm) |=> zero_flag_ff == (result_seen == 8'h00) &&
      {carry_flag_ff, result_seen} ==
      sbcsf_sub9($past(opnd), $past(working_register_ff), $past(carry_flag_ff)))
    else $error("zero or carry flag wrong");

  chk_store_copy_out: assert property (
    s_store ##0 (instr_ssel <= SPAGE_LAST) |=>
      spage_we_ff && spage_sel_ff == $past(instr_ssel) &&
      spage_wdata_ff == $past(working_register_ff) ##1 (!spage_we_ff || done_ff))
    else $error("special page store wrong");

  chk_store_keeps_state: assert property (
    s_store |=> done_ff && $stable(working_register_ff) && $stable(carry_flag_ff) &&
      $stable(zero_flag_ff) && $stable(low_nibble_carry_flag_ff) && !file_we_ff)
    else $error("store altered state");

  chk_store_range_drop: assert property (
    s_store ##0 (instr_ssel > SPAGE_LAST) |=> !spage_we_ff)
    else $error("out of page store written");

  chk_imm_into_wreg: assert property (
    s_sub_imm |=> !file_we_ff && {carry_flag_ff, working_register_ff} ==
      sbcsf_sub9($past(instr_imm), $past(working_register_ff), $past(carry_flag_ff)))
    else $error("immediate subtract result wrong");

  chk_nibble_carry: assert property (
    (s_sub_reg or s_sub_imm) |=> {low_nibble_carry_flag_ff, 4'h0} ==
      (sbcsf_sub5($past(opnd), $past(working_register_ff), $past(carry_flag_ff)) & 5'h10))
    else $error("nibble carry wrong");

endmodule : sbcsf_exec

// ### sbcsf_pkg.sv
// Shared constants, operation codes and the borrow adder functions
package sbcsf_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned RADDR_W    = 7;
  localparam int unsigned SSEL_W     = 5;
  localparam int unsigned NIB_W      = 4;
  localparam logic [4:0]  SPAGE_LAST = 5'h15;
  localparam logic [7:0]  WREG_RST   = 8'h00;
  localparam logic        FLAG_RST   = 1'b0;
  localparam logic        DEST_WREG  = 1'b0;
  localparam logic        DEST_FILE  = 1'b1;

  typedef enum logic [1:0] {
    SBCSF_OP_NONE      = 2'b00,
    SBCSF_OP_SUB_REG   = 2'b01,
    SBCSF_OP_SUB_IMM   = 2'b10,
    SBCSF_OP_STORE_SP  = 2'b11
  } sbcsf_op_t;

  // Operand plus complemented working value plus carry, carry out on top
  function automatic logic [8:0] sbcsf_sub9(
    input logic [7:0] opnd,
    input logic [7:0] wreg,
    input logic       cin
  );
    sbcsf_sub9 = {1'b0, opnd} + {1'b0, ~wreg} + {8'h00, cin};
  endfunction : sbcsf_sub9

  // Same path on the low nibble; bit 4 is the nibble carry
  function automatic logic [4:0] sbcsf_sub5(
    input logic [7:0] opnd,
    input logic [7:0] wreg,
    input logic       cin
  );
    sbcsf_sub5 = {1'b0, opnd[3:0]} + {1'b0, ~wreg[3:0]} + {4'h0, cin};
  endfunction : sbcsf_sub5

endpackage : sbcsf_pkg

// ### sbcsf_adder.sv
// Borrow adder: sum, carry, nibble carry and zero detect
`timescale 1ns/1ps
module sbcsf_adder
  import sbcsf_pkg::*;
(
  input  wire logic [7:0] opnd,
  input  wire logic [7:0] wreg,
  input  wire logic       cin,
  output logic      [7:0] sum,
  output logic            cout,
  output logic            nib_cout,
  output logic            zero
);

  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    full     = sbcsf_sub9(opnd, wreg, cin);
    low      = sbcsf_sub5(opnd, wreg, cin);
    sum      = full[7:0];
    cout     = full[8];
    nib_cout = low[4];
    zero     = (full[7:0] == 8'h00);
  end

endmodule : sbcsf_adder

// ### subtract_borrow_sfr_load_tb.sv
// Self-checking bench for the subtract-with-borrow and special page store stage
`timescale 1ns/1ps
module subtract_borrow_sfr_load_tb
  import sbcsf_pkg::*;
;
  logic clk, nrst, instr_valid, instr_dest;
  sbcsf_op_t instr_op;
  logic [6:0] instr_raddr;
  logic [7:0] instr_imm, file_rdata, working_register_ff, file_wdata_ff, spage_wdata_ff;
  logic [4:0] instr_ssel, spage_sel_ff;
  logic [6:0] file_waddr_ff;
  logic carry_flag_ff, zero_flag_ff, low_nibble_carry_flag_ff, file_we_ff, spage_we_ff, done_ff;
  logic [7:0] m_w, e_fdata, e_sdata;
  logic m_c, m_z, m_dc, e_fwe, e_swe, e_done;
  logic [6:0] e_faddr;
  logic [4:0] e_ssel;
  int err_total, total_checks;
  ////////////////////////////////////////////////////////////////////////////////
  sbcsf_exec u_sbcsf_exec (.clk(clk), .nrst(nrst), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_raddr(instr_raddr), .instr_dest(instr_dest),
    .instr_imm(instr_imm), .instr_ssel(instr_ssel), .file_rdata(file_rdata),
    .working_register_ff(working_register_ff), .carry_flag_ff(carry_flag_ff),
    .zero_flag_ff(zero_flag_ff), .low_nibble_carry_flag_ff(low_nibble_carry_flag_ff),
    .file_we_ff(file_we_ff), .file_waddr_ff(file_waddr_ff), .file_wdata_ff(file_wdata_ff),
    .spage_we_ff(spage_we_ff), .spage_sel_ff(spage_sel_ff),
    .spage_wdata_ff(spage_wdata_ff), .done_ff(done_ff));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // Results of the op taken at the last edge are settled 1 ns later
  always @(posedge clk) begin
    #1;
    chk(working_register_ff, m_w);
    chk({7'h00, carry_flag_ff}, {7'h00, m_c});
    chk({7'h00, zero_flag_ff}, {7'h00, m_z});
    chk({7'h00, low_nibble_carry_flag_ff}, {7'h00, m_dc});
    chk({7'h00, file_we_ff}, {7'h00, e_fwe});
    chk({7'h00, spage_we_ff}, {7'h00, e_swe});
    chk({7'h00, done_ff}, {7'h00, e_done});
    if (e_fwe) begin
      chk({1'b0, file_waddr_ff}, {1'b0, e_faddr});
      chk(file_wdata_ff, e_fdata);
    end
    if (e_swe) begin
      chk({3'h0, spage_sel_ff}, {3'h0, e_ssel});
      chk(spage_wdata_ff, e_sdata);
    end
    e_fwe = 1'b0;
    e_swe = 1'b0;
    e_done = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Called at an edge; returns at the taking edge so ops can chain
  task automatic step(input sbcsf_op_t op, input logic [7:0] opnd, input logic dest,
                      input logic [6:0] ra, input logic [4:0] ss);
    logic [8:0] s9;
    logic [4:0] n5;
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_imm <= opnd;
    file_rdata <= opnd;
    instr_dest <= dest;
    instr_raddr <= ra;
    instr_ssel <= ss;
    @(posedge clk);
    s9 = {1'b0, opnd} + {1'b0, ~m_w} + {8'h00, m_c};
    n5 = {1'b0, opnd[3:0]} + {1'b0, ~m_w[3:0]} + {4'h0, m_c};
    e_done = (op != SBCSF_OP_NONE);
    if (op == SBCSF_OP_SUB_REG || op == SBCSF_OP_SUB_IMM) begin
      m_c = s9[8];
      m_z = (s9[7:0] == 8'h00);
      m_dc = n5[4];
      if (op == SBCSF_OP_SUB_IMM || dest == DEST_WREG) m_w = s9[7:0];
      else begin
        e_fwe = 1'b1;
        e_faddr = ra;
        e_fdata = s9[7:0];
      end
    end
    if (op == SBCSF_OP_STORE_SP && ss <= 5'h15) begin
      e_swe = 1'b1;
      e_ssel = ss;
      e_sdata = m_w;
    end
  endtask : step
  task automatic idle();
    instr_valid <= 1'b0;
    instr_op <= SBCSF_OP_NONE;
    @(posedge clk);
  endtask : idle
  task automatic do_reset();
    nrst <= 1'b0;
    idle();
    {m_w, m_c, m_z, m_dc} = 11'h000;
    @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_sub_imm();
    logic [7:0] tbl [6] = '{8'h07, 8'h05, 8'h00, 8'hFF, 8'h10, 8'h0F};
    foreach (tbl[i]) step(SBCSF_OP_SUB_IMM, tbl[i], 1'b1, 7'h7F, 5'h15);
    idle();
  endtask : t_sub_imm
  task automatic t_sub_reg();
    logic [7:0] rd [5] = '{8'h05, 8'h05, 8'h06, 8'h00, 8'hF0};
    logic [6:0] ra [5] = '{7'h00, 7'h7F, 7'h2A, 7'h01, 7'h55};
    foreach (rd[i]) begin
      step(SBCSF_OP_SUB_REG, rd[i], ~i[0], ra[i], 5'h00);
      idle();
    end
  endtask : t_sub_reg
  task automatic t_store();
    logic [4:0] ss [4] = '{5'h00, 5'h15, 5'h16, 5'h1F};
    foreach (ss[i]) step(SBCSF_OP_STORE_SP, 8'hA5, 1'b1, 7'h10, ss[i]);
    idle();
  endtask : t_store
  task automatic t_chain();
    step(SBCSF_OP_SUB_IMM, 8'h06, 1'b0, 7'h00, 5'h00);
    step(SBCSF_OP_STORE_SP, 8'h00, 1'b0, 7'h00, 5'h03);
    step(SBCSF_OP_SUB_REG, 8'h80, 1'b0, 7'h33, 5'h00);
    step(SBCSF_OP_SUB_REG, 8'h06, 1'b1, 7'h7F, 5'h15);
    step(SBCSF_OP_STORE_SP, 8'h00, 1'b0, 7'h00, 5'h15);
    idle();
  endtask : t_chain
  // Op lines set without valid, then valid with no op: neither may act
  task automatic t_ignore();
    instr_valid <= 1'b0;
    instr_op <= SBCSF_OP_SUB_IMM;
    @(posedge clk);
    step(SBCSF_OP_NONE, 8'h33, 1'b1, 7'h01, 5'h01);
    idle();
  endtask : t_ignore
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, instr_valid, instr_dest, instr_raddr, instr_imm, file_rdata, instr_ssel} = '0;
    instr_op = SBCSF_OP_NONE;
    {m_w, m_c, m_z, m_dc, e_fwe, e_swe, e_done} = '0;
    err_total = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_sub_imm();
    t_sub_reg();
    t_store();
    t_chain();
    t_ignore();
    do_reset();
    t_chain();
    idle();
    summarize();
  end
  // Bound on the whole run
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule : subtract_borrow_sfr_load_tb
